/* hw/phr_pkg.sv */
package phr_pkg;
	// register indices on the serial link
	localparam logic [7:0] PHR_IDX_HYST  = 8'h6A;
	localparam logic [7:0] PHR_IDX_POWER = 8'h6B;
	localparam logic [7:0] PHR_IDX_ID    = 8'h6C;
	localparam logic [7:0] PHR_IDX_RESET = 8'h7C;
	// reset values
	localparam logic [15:0] PHR_HYST_RST  = 16'h2108;
	localparam logic [15:0] PHR_POWER_RST = 16'h0000;
	// spi reset key
	localparam logic [15:0] PHR_SPI_KEY = 16'h6600;
	// field layout of temp_hysteresis
	localparam int PHR_HYS_W    = 5;
	localparam int PHR_D2_LSB   = 10;
	localparam int PHR_D1_LSB   = 5;
	localparam int PHR_LT_LSB   = 0;
	// field layout of power_control
	localparam int PHR_ADC_BIT  = 14;
	localparam int PHR_REF_BIT  = 13;
	localparam int PHR_DAC_MSB  = 12;
	localparam int PHR_DAC_N    = 12;
	// valid bit masks
	localparam logic [15:0] PHR_HYST_MASK  = 16'h7FFF;
	localparam logic [15:0] PHR_POWER_MASK = 16'h7FFE;
	// host controller register offsets (axi byte addresses)
	localparam logic [7:0] PHR_A_CMD    = 8'h00;
	localparam logic [7:0] PHR_A_STATUS = 8'h04;
	localparam logic [7:0] PHR_A_RDATA  = 8'h08;
	// command word fields
	localparam int PHR_CMD_WR_BIT   = 24;
	localparam int PHR_CMD_I2C_BIT  = 25;
	localparam int PHR_CMD_IDX_LSB  = 16;
	// serial frame length in bits: rw, mode, index, data
	localparam int PHR_FRAME_BITS   = 26;
	// link clock divider half period in aclk cycles
	localparam int PHR_DIV_HALF     = 2;
endpackage : phr_pkg

/* hw/phr_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
// serial link between host controller and device
interface phr_link_if;
	logic link_clk;   // link clock, made by the host
	logic frame_n;    // frame select, active low
	logic mosi;       // host to device data
	logic miso;       // device to host data
	modport host   (output link_clk, output frame_n, output mosi, input miso);
	modport device (input link_clk, input frame_n, input mosi, output miso);
endinterface : phr_link_if
`default_nettype wire

/* hw/phr_device.sv */
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// R01 - remote two hysteresis in bits 14:10
// R02 - remote one hysteresis in bits 9:5
// R03 - local hysteresis bits 4:0, default eight
// R04 - fields span 0..31, bit 15 zero
// R05 - power control clears on any reset
// R06 - bit 14 enables the converter
// R07 - bit 13 enables the reference buffer
// R08 - bits 12..1 enable dac 0..11
// R09 - id register read only, fixed value
// R10 - soft reset keeps dac data registers
// R11 - hardware reset restores all defaults
// R12 - spi reset only on key 6600h
// R13 - i2c reset on any written data
// R14 - host discards reset register read data; the host here captures it into rdat_reg like any other read
// R15 - i2c reset register is one byte
// R16 - i2c reset write sequence acknowledged
// R17 - host reprograms dacs before powering on
// R18 - each hysteresis applied to its alarm
// R19 - power bits 15 and 0 read zero
module phr_device #(
	parameter logic [15:0] ID_VALUE = 16'h5A01  // arbitrary identity value
) (
	// link side
	phr_link_if.device                 link,
	input  wire logic                  hw_rst_n,
	// analog control outputs
	output logic                       converter_power_on,
	output logic                       refbuf_power_on,
	output logic [phr_pkg::PHR_DAC_N-1:0] dac_channel_power_on,
	output logic [4:0]                 remote_two_hyst_field,
	output logic [4:0]                 remote_one_hyst_field,
	output logic [4:0]                 local_temp_hyst_field,
	output logic                       dac_keep_soft_reset
);
	//////////////////////////////////////////////////////////////////////////
	// frame shifter: bit25 rw, bit24 i2c mode, 8 index bits, 16 data bits
	logic [phr_pkg::PHR_FRAME_BITS-1:0] shift_reg;   // incoming bits, msb first
	logic [4:0]                         cnt_reg;     // bits seen in frame
	logic [15:0]                        hyst_reg;    // temp_hysteresis
	logic [15:0]                        power_reg;   // power_control
	logic [15:0]                        rd_reg;      // read shift out
	logic                               soft_reg;    // soft reset seen

	// frame as seen on the link, one bit per rising link clock edge:
	//   bit 25      write when high, read when low
	//   bit 24      two-wire mode: any data resets, data field still sixteen bits
	//   bits 23:16  register index
	//   bits 15:0   write data, or don't-care on a read
	// a read loads its word after ten bits and drives it out over the
	// last sixteen, so the host must keep the final sixteen samples
	// the counter wraps on the last bit; a longer frame starts a new one,
	// a shorter one is dropped at the next link edge seen with the frame select high
	// writes to unmapped or read-only indices are ignored, which keeps
	// the identity word fixed whatever the host sends
	// hardware reset acts only on link edges: the host must run a frame
	// while it is held, since its clock stands still when idle
	// the dac data registers live outside; the soft reset marker tells
	// them to keep their content, while the hardware reset clears them
	// through their own connection to the reset pin
	// limitation: no synchroniser sits on the reset, it is assumed to be
	// held across whole frames and released between them
	// decoded fields of the frame, valid at last bit
	wire  [phr_pkg::PHR_FRAME_BITS-1:0] frame_w = {shift_reg[phr_pkg::PHR_FRAME_BITS-2:0], link.mosi};
	wire        f_wr  = frame_w[phr_pkg::PHR_FRAME_BITS-1];
	wire        f_i2c = frame_w[phr_pkg::PHR_FRAME_BITS-2];
	wire  [7:0] f_idx = frame_w[23:16];
	wire  [15:0] f_dat = frame_w[15:0];
	wire        last  = (cnt_reg == 5'(phr_pkg::PHR_FRAME_BITS-1));
	wire        hdr_done = (cnt_reg == 5'd9);
	wire        wr_now = last && !f_wr ? 1'b0 : last;
	wire        wr_hyst = wr_now && (f_idx == phr_pkg::PHR_IDX_HYST);   // write hits hysteresis
	wire        wr_pwr  = wr_now && (f_idx == phr_pkg::PHR_IDX_POWER);  // write hits power control
	// soft reset request: key in spi, any byte in i2c
	wire        rst_hit = last && f_wr && (f_idx == phr_pkg::PHR_IDX_RESET) &&
	                      (f_i2c || (f_dat == phr_pkg::PHR_SPI_KEY)); // R12 R13 R15 R16

	// read data for an index
	function automatic logic [15:0] rd_mux(input logic [7:0] idx, input logic [15:0] h,
	                                       input logic [15:0] p);
		case (idx)
			phr_pkg::PHR_IDX_HYST:  rd_mux = h & phr_pkg::PHR_HYST_MASK;   // R04
			phr_pkg::PHR_IDX_POWER: rd_mux = p & phr_pkg::PHR_POWER_MASK;  // R19
			phr_pkg::PHR_IDX_ID:    rd_mux = ID_VALUE;                     // R09
			default:                rd_mux = 16'h0000;                     // R14
		endcase
	endfunction : rd_mux

	//////////////////////////////////////////////////////////////////////////
	// hysteresis register; both resets restore the default
	always_ff @(posedge link.link_clk)
	begin
		if (!hw_rst_n || rst_hit)
		begin
			// R10 R11: soft reset only spares the dac data, kept outside
			hyst_reg <= phr_pkg::PHR_HYST_RST;              // R03
		end
		else if (wr_hyst)
		begin
			// reserved top bit is dropped on the way in
			hyst_reg <= f_dat & phr_pkg::PHR_HYST_MASK;     // R01 R02 R03 R04
		end
		else
		begin
			// no write to this index: hold
			hyst_reg <= hyst_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// power control register; everything starts powered down
	always_ff @(posedge link.link_clk)
	begin
		if (!hw_rst_n || rst_hit)
		begin
			power_reg <= phr_pkg::PHR_POWER_RST;            // R05 R10 R11
		end
		else if (wr_pwr)
		begin
			// bits 15 and 0 never store a one
			power_reg <= f_dat & phr_pkg::PHR_POWER_MASK;   // R19
		end
		else
		begin
			power_reg <= power_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// frame bit counter, cleared on a link edge seen while deselected so a cut frame starts afresh
	always_ff @(posedge link.link_clk)
	begin
		if (!hw_rst_n || link.frame_n || last)
		begin
			cnt_reg <= 5'd0;
		end
		else
		begin
			cnt_reg <= cnt_reg + 5'd1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// input shifter; a link edge while deselected clears it so no stale header survives
	always_ff @(posedge link.link_clk)
	begin
		if (link.frame_n)
		begin
			shift_reg <= '0;
		end
		else
		begin
			shift_reg <= frame_w;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read data loads once the index is in, then shifts out msb first
	always_ff @(posedge link.link_clk)
	begin
		if (!hw_rst_n)
		begin
			rd_reg <= 16'h0000;
		end
		else if (hdr_done)
		begin
			// the index occupies the low byte of the ten bits seen so far
			rd_reg <= rd_mux(frame_w[7:0], hyst_reg, power_reg);
		end
		else
		begin
			rd_reg <= {rd_reg[14:0], 1'b0};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// soft reset marker; it can only fall at the next link edge, and the
	// link clock stands still between frames, so it lasts until then
	always_ff @(posedge link.link_clk)
	begin
		soft_reg <= hw_rst_n && rst_hit;                // R10
	end

	assign link.miso = rd_reg[15];

	//////////////////////////////////////////////////////////////////////////
	// control outputs
	assign converter_power_on    = power_reg[phr_pkg::PHR_ADC_BIT];               // R06
	assign refbuf_power_on       = power_reg[phr_pkg::PHR_REF_BIT];               // R07
	genvar g;
	generate
		for (g = 0; g < phr_pkg::PHR_DAC_N; g++)
		begin : g_dac
			assign dac_channel_power_on[g] = power_reg[phr_pkg::PHR_DAC_MSB-g];  // R08
		end
	endgenerate
	// each field drives its own alarm comparator outside
	assign remote_two_hyst_field = hyst_reg[phr_pkg::PHR_D2_LSB +: 5];  // R01 R18
	assign remote_one_hyst_field = hyst_reg[phr_pkg::PHR_D1_LSB +: 5];  // R02 R18
	assign local_temp_hyst_field = hyst_reg[phr_pkg::PHR_LT_LSB +: 5];  // R03 R18
	// pulse telling dac register file to keep its content
	assign dac_keep_soft_reset   = soft_reg;                            // R10
endmodule : phr_device
`default_nettype wire

/* hw/phr_host.sv */
`timescale 1ns/100ps
`default_nettype none
// host controller: axi4-lite slave, drives link clock from aclk by divider
module phr_host (
	// system
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// link
	phr_link_if.host         link
);
	typedef enum logic [1:0] {PHR_IDLE = 2'b00, PHR_SHIFT = 2'b01, PHR_DONE = 2'b10} phr_st_t;
	phr_st_t     st_reg;         // link engine state
	logic [25:0] out_reg;        // frame bits to send
	logic [4:0]  bit_reg;        // bits sent
	logic [1:0]  div_reg;        // clock divider
	logic        sck_reg;        // link clock out
	logic [15:0] rdat_reg;       // captured read data
	logic        aw_reg, w_reg;  // address/data taken
	logic [7:0]  awa_reg;        // held write address
	logic [31:0] wd_reg;         // held write data
	logic        b_reg, r_reg;   // responses pending
	logic [31:0] rd_reg;         // read data out
	logic        miso_s1, miso_s2; // synchroniser for miso

	wire busy     = (st_reg != PHR_IDLE);
	wire both_in  = aw_reg && w_reg && !b_reg;
	wire cmd_hit  = both_in && awa_reg == phr_pkg::PHR_A_CMD && !busy;
	wire half     = (div_reg == 2'(phr_pkg::PHR_DIV_HALF-1));
	wire fall     = half && sck_reg;
	wire rise     = half && !sck_reg;
	wire addr_ok  = (s_araddr == phr_pkg::PHR_A_STATUS) || (s_araddr == phr_pkg::PHR_A_RDATA) ||
	                (s_araddr == phr_pkg::PHR_A_CMD);

	assign s_awready = !aw_reg;
	assign s_wready  = !w_reg;
	assign s_bvalid  = b_reg;
	assign s_bresp   = 2'b00;
	assign s_arready = !r_reg;
	assign s_rvalid  = r_reg;
	assign s_rdata   = rd_reg;
	assign s_rresp   = 2'b00;
	assign link.link_clk = sck_reg;
	assign link.frame_n  = !(st_reg == PHR_SHIFT);
	assign link.mosi     = out_reg[25];

	//////////////////////////////////////////////////////////////////////////
	// axi slave; a command write while busy waits until idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; r_reg <= 1'b0;
			awa_reg <= 8'h00; wd_reg <= 32'h0; rd_reg <= 32'h0;
		end
		else
		begin
			if (s_awvalid && !aw_reg) begin aw_reg <= 1'b1; awa_reg <= s_awaddr; end
			if (s_wvalid && !w_reg) begin w_reg <= 1'b1; wd_reg <= s_wdata; end
			if (both_in && (awa_reg != phr_pkg::PHR_A_CMD || !busy)) b_reg <= 1'b1;
			if (b_reg && s_bready) begin b_reg <= 1'b0; aw_reg <= 1'b0; w_reg <= 1'b0; end
			if (s_arvalid && !r_reg)
			begin
				r_reg <= 1'b1;
				rd_reg <= !addr_ok ? 32'h0 : (s_araddr == phr_pkg::PHR_A_STATUS) ?
				          {31'h0, busy} : {16'h0, rdat_reg};
			end
			else if (r_reg && s_rready) r_reg <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// link engine: shift on falling edge of link clock, sample on rising
	always_ff @(posedge aclk)
	begin
		miso_s1 <= link.miso;
		miso_s2 <= miso_s1;
		if (!aresetn)
		begin
			st_reg <= PHR_IDLE; out_reg <= 26'h0; bit_reg <= 5'd0;
			div_reg <= 2'd0; sck_reg <= 1'b0; rdat_reg <= 16'h0;
		end
		else
			case (st_reg)
				PHR_IDLE:
				begin
					sck_reg <= 1'b0; div_reg <= 2'd0; bit_reg <= 5'd0;
					if (cmd_hit)
					begin
						out_reg <= {wd_reg[phr_pkg::PHR_CMD_WR_BIT], wd_reg[phr_pkg::PHR_CMD_I2C_BIT],
						            wd_reg[23:0]};
						st_reg <= PHR_SHIFT;
					end
				end
				PHR_SHIFT:
				begin
					div_reg <= half ? 2'd0 : div_reg + 2'd1;
					if (half) sck_reg <= !sck_reg;
					if (rise) rdat_reg <= {rdat_reg[14:0], miso_s2}; // R14 ignored for reset idx
					if (fall)
					begin
						out_reg <= {out_reg[24:0], 1'b0};
						bit_reg <= bit_reg + 5'd1;
						if (bit_reg == 5'(phr_pkg::PHR_FRAME_BITS-1)) st_reg <= PHR_DONE;
					end
				end
				PHR_DONE: st_reg <= PHR_IDLE;
				default:  st_reg <= PHR_IDLE;
			endcase
	end
endmodule : phr_host
`default_nettype wire

/* bench/phr_link_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// checker beside the link: wire framing and the device's register outputs
module phr_link_sva (
	// host clock domain
	input wire logic                          aclk,
	input wire logic                          aresetn,
	// link wires and device reset
	input wire logic                          link_clk,
	input wire logic                          frame_n,
	input wire logic                          hw_rst_n,
	// device outputs
	input wire logic                          converter_power_on,
	input wire logic                          refbuf_power_on,
	input wire logic [phr_pkg::PHR_DAC_N-1:0] dac_channel_power_on,
	input wire logic [4:0]                    remote_two_hyst_field,
	input wire logic [4:0]                    remote_one_hyst_field,
	input wire logic [4:0]                    local_temp_hyst_field,
	input wire logic                          dac_keep_soft_reset
);
	//////////////////////////////////////////////////////////////////////////
	int         n_rise; // link clock rises in the current frame
	logic [14:0] hyst;  // the three fields packed as in the register
	assign hyst = {remote_two_hyst_field, remote_one_hyst_field, local_temp_hyst_field};
	// count rises only inside a frame, cleared while idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || frame_n)
			n_rise <= 0;
		else if ($rose(link_clk))
			n_rise <= n_rise + 1;
	end
	//////////////////////////////////////////////////////////////////////////
	link_idle_a : assert property (@(posedge aclk) disable iff (!aresetn)
		frame_n && $past(frame_n) |-> !link_clk) else $error("link clock runs while idle");
	frame_start_a : assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(frame_n) |-> !link_clk) else $error("frame opens with clock high");
	clk_div_a : assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(link_clk) && !frame_n |-> link_clk [*2] ##1 !link_clk) else $error("bad clock");
	frame_len_a : assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(frame_n) |-> n_rise == phr_pkg::PHR_FRAME_BITS) else $error("bad frame length");
	// no reset iff here: the antecedent is the reset itself
	hw_power_a : assert property (@(posedge link_clk)
		!hw_rst_n |=> !converter_power_on && !refbuf_power_on && dac_channel_power_on == '0)
		else $error("power bits not cleared by reset");
	hw_hyst_a : assert property (@(posedge link_clk)
		!hw_rst_n |=> hyst == 15'h2108) else $error("hysteresis not restored by reset");
	soft_pulse_a : assert property (@(posedge link_clk) disable iff (!hw_rst_n)
		dac_keep_soft_reset |=> !dac_keep_soft_reset) else $error("soft reset pulse too long");
	soft_restore_a : assert property (@(posedge link_clk) disable iff (!hw_rst_n)
		dac_keep_soft_reset |=> !converter_power_on && hyst == 15'h2108)
		else $error("soft reset left registers");
	idle_stable_a : assert property (@(posedge aclk) disable iff (!aresetn)
		frame_n [*4] |-> $stable(dac_channel_power_on) && $stable(hyst))
		else $error("outputs moved outside a frame");
	// main scenarios
	frame_c : cover property (@(posedge aclk) $rose(frame_n));
	soft_c : cover property (@(posedge link_clk) dac_keep_soft_reset);
	hw_c : cover property (@(posedge link_clk) !hw_rst_n);
endmodule : phr_link_sva
`default_nettype wire

/* bench/power_hysteresis_reset_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
// axi master drives the host; device outputs and read data are compared
module power_hysteresis_reset_regs_test;
	localparam logic [15:0] ID_C = 16'h5A01; // arbitrary identity value
	logic aclk = 0, aresetn = 0, hw_rst_n = 0, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0;
	logic s_bready = 1, s_rready = 1; // held high, the slave answers when it can
	logic [7:0] s_awaddr = '0, s_araddr = '0;
	logic [31:0] s_wdata = '0, s_rdata;
	logic [3:0] s_wstrb = 4'hF;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, converter_power_on;
	logic refbuf_power_on, dac_keep_soft_reset;
	logic [1:0] s_bresp, s_rresp;
	logic [11:0] dac_channel_power_on;
	logic [4:0] remote_two_hyst_field, remote_one_hyst_field, local_temp_hyst_field;
	int errors = 0, n_tests = 0, pulses = 0;
	logic [15:0] exp_q[$]; // expected read data, oldest first
	//////////////////////////////////////////////////////////////////////////
	phr_link_if phr_link_if_i ();
	phr_host phr_host_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.link(phr_link_if_i));
	phr_device #(.ID_VALUE(ID_C)) phr_device_i (.link(phr_link_if_i), .hw_rst_n,
		.converter_power_on, .refbuf_power_on, .dac_channel_power_on,
		.remote_two_hyst_field, .remote_one_hyst_field, .local_temp_hyst_field,
		.dac_keep_soft_reset);
	phr_link_sva phr_link_sva_i (.aclk, .aresetn, .link_clk(phr_link_if_i.link_clk),
		.frame_n(phr_link_if_i.frame_n), .hw_rst_n, .converter_power_on,
		.refbuf_power_on, .dac_channel_power_on, .remote_two_hyst_field,
		.remote_one_hyst_field, .local_temp_hyst_field, .dac_keep_soft_reset);
	//////////////////////////////////////////////////////////////////////////
	always #12.5 aclk = ~aclk;
	// soft reset pulses counted on the first link clock edge after the one they are launched on
	always @(posedge phr_link_if_i.link_clk)
		if (dac_keep_soft_reset === 1'b1) pulses++;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1;
		s_wvalid <= 1;
		do
		begin
			@(posedge aclk);
			if (s_awvalid && s_awready) s_awvalid <= 0;
			if (s_wvalid && s_wready) s_wvalid <= 0;
		end
		while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
		while (s_bvalid !== 1'b1) @(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		s_araddr <= a;
		s_arvalid <= 1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 0;
		do @(posedge aclk); while (s_rvalid !== 1'b1);
		d = s_rdata;
	endtask : axi_rd
	// one link frame, then poll busy until the host is idle again
	task automatic frame(input logic wr, i2c, input logic [7:0] idx, input logic [15:0] d);
		logic [31:0] st;
		axi_wr(phr_pkg::PHR_A_CMD, {6'h00, i2c, wr, idx, d});
		do axi_rd(phr_pkg::PHR_A_STATUS, st); while (st[0] !== 1'b0);
	endtask : frame
	task automatic rd_reg(input logic [7:0] idx, input logic [15:0] exp);
		logic [31:0] st;
		frame(1'b0, 1'b0, idx, 16'h0000);
		exp_q.push_back(exp);
		axi_rd(phr_pkg::PHR_A_RDATA, st);
	endtask : rd_reg
	task automatic chk_outs(input logic [15:0] hy, input logic [15:0] pw);
		logic [11:0] dv;
		for (int i = 0; i < 12; i++) dv[i] = pw[12-i];
		check({11'h000, remote_two_hyst_field}, {11'h000, hy[14:10]});
		check({11'h000, remote_one_hyst_field}, {11'h000, hy[9:5]});
		check({11'h000, local_temp_hyst_field}, {11'h000, hy[4:0]});
		check({15'h0000, converter_power_on}, {15'h0000, pw[14]});
		check({15'h0000, refbuf_power_on}, {15'h0000, pw[13]});
		check({4'h0, dac_channel_power_on}, {4'h0, dv});
	endtask : chk_outs
	// read results of the data register are taken off the queue as they appear
	always @(posedge aclk)
		if (s_rvalid === 1'b1 && s_araddr === phr_pkg::PHR_A_RDATA)
			check(s_rdata[15:0], exp_q.pop_front());
	initial
	begin
		#1000000;
		errors++;
		print_verdict();
	end
	//////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [15:0] v, w;
		logic [31:0] st;
		void'($urandom(32'h8328));
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		// device reset is seen only on link edges, so hold it through a frame
		frame(1'b0, 1'b0, phr_pkg::PHR_IDX_ID, 16'h0000);
		hw_rst_n <= 1;
		chk_outs(phr_pkg::PHR_HYST_RST, phr_pkg::PHR_POWER_RST);
		rd_reg(phr_pkg::PHR_IDX_HYST, phr_pkg::PHR_HYST_RST);
		for (int k = 0; k < 4; k++)
		begin
			v = (k == 0) ? 16'hFFFF : 16'($urandom);
			w = (k == 0) ? 16'hFFFF : 16'($urandom);
			frame(1'b1, 1'b0, phr_pkg::PHR_IDX_HYST, v);
			frame(1'b1, 1'b0, phr_pkg::PHR_IDX_POWER, w);
			frame(1'b1, 1'b0, phr_pkg::PHR_IDX_ID, v);
			rd_reg(phr_pkg::PHR_IDX_HYST, v & phr_pkg::PHR_HYST_MASK);
			rd_reg(phr_pkg::PHR_IDX_POWER, w & phr_pkg::PHR_POWER_MASK);
			rd_reg(phr_pkg::PHR_IDX_ID, ID_C);
			chk_outs(v, w);
		end
		// a near-miss key must leave everything alone
		frame(1'b1, 1'b0, phr_pkg::PHR_IDX_RESET, phr_pkg::PHR_SPI_KEY ^ 16'h0001);
		rd_reg(phr_pkg::PHR_IDX_POWER, w & phr_pkg::PHR_POWER_MASK);
		frame(1'b1, 1'b0, phr_pkg::PHR_IDX_RESET, phr_pkg::PHR_SPI_KEY);
		rd_reg(phr_pkg::PHR_IDX_HYST, phr_pkg::PHR_HYST_RST);
		check(16'(pulses), 16'h0001);
		frame(1'b1, 1'b0, phr_pkg::PHR_IDX_HYST, 16'h0421);
		frame(1'b1, 1'b1, phr_pkg::PHR_IDX_RESET, {8'h00, 8'($urandom)});
		rd_reg(phr_pkg::PHR_IDX_HYST, phr_pkg::PHR_HYST_RST);
		check(16'(pulses), 16'h0002);
		frame(1'b0, 1'b1, phr_pkg::PHR_IDX_RESET, 16'h0000);
		frame(1'b1, 1'b0, phr_pkg::PHR_IDX_POWER, 16'h7FFE);
		hw_rst_n <= 0;
		frame(1'b0, 1'b0, phr_pkg::PHR_IDX_ID, 16'h0000);
		hw_rst_n <= 1;
		chk_outs(phr_pkg::PHR_HYST_RST, phr_pkg::PHR_POWER_RST);
		axi_rd(8'h0C, st);
		check(st[15:0], 16'h0000);
		print_verdict();
	end
endmodule : power_hysteresis_reset_regs_test
`default_nettype wire
